/* line_diag_control_regs.sv */
// Per-channel line diagnostics control registers with pattern generator and loopback steering
`timescale 1ns/1ps
module line_diag_control_regs (
	input  wire logic                                         clk,
	input  wire logic                                         rst_n,
	input  wire logic [7:0]                                   paddr,
	input  wire logic                                         psel,
	input  wire logic                                         penable,
	input  wire logic                                         pwrite,
	input  wire logic [31:0]                                  pwdata,
	output logic [31:0]                                       prdata,
	output logic                                              pready,
	output logic                                              pslverr,
	input  wire line_diag_pkg::chan_in_t  [line_diag_pkg::NUM_CHAN-1:0] chanIn,
	output line_diag_pkg::chan_out_t [line_diag_pkg::NUM_CHAN-1:0] chanOut
);
	import line_diag_pkg::*;

	diag_state_t                 s_reg;
	diag_state_t                 s_next;
	logic [5:0]                  regIdx;
	logic                        hit;
	logic                        hitChan;
	logic [1:0]                  hitKind;
	logic [NUM_CHAN-1:0]         bitEn;
	logic [NUM_CHAN-1:0]         prbsFb;

	assign regIdx = paddr[7:2];

	// Decode: hitKind 0 receiver config, 1 pattern, 2 loopback
	always_comb begin
		hit = 1'b1;
		hitChan = 1'b0;
		hitKind = 2'd0;
		case (regIdx)
			CH1_RX_CFG2_IDX: hitKind = 2'd0;
			CH1_PAT_CTRL_IDX: hitKind = 2'd1;
			CH1_LOOP_CTRL_IDX: hitKind = 2'd2;
			CH2_RX_CFG2_IDX: begin
				hitChan = 1'b1;
				hitKind = 2'd0;
			end
			CH2_PAT_CTRL_IDX: begin
				hitChan = 1'b1;
				hitKind = 2'd1;
			end
			CH2_LOOP_CTRL_IDX: begin
				hitChan = 1'b1;
				hitKind = 2'd2;
			end
			default: hit = 1'b0;
		endcase
	end

	// Zero wait states; read data is captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = s_reg.prdata;

	always_comb begin
		chan_state_t c;
		logic        patBit;
		logic [1:0]  patSel;
		logic        losNow;
		c = '0;
		patBit = 1'b0;
		patSel = 2'b00;
		losNow = 1'b0;
		s_next = s_reg;
		bitEn = '0;
		prbsFb = '0;

		if (s_reg.mclkCnt == MCLK_DIV - 5'd1) begin
			s_next.mclkCnt = 5'd0;
			s_next.mclkEn = 1'b1;
		end else begin
			s_next.mclkCnt = s_reg.mclkCnt + 5'd1;
			s_next.mclkEn = 1'b0;
		end

		if (psel && !penable) begin
			s_next.prdata = 32'h0000_0000;
			if (hit) begin
				case (hitKind)
					2'd0: s_next.prdata[7:0] = s_reg.ch[hitChan].cfg;
					2'd1: s_next.prdata[7:0] = s_reg.ch[hitChan].pat;
					default: s_next.prdata[7:0] = s_reg.ch[hitChan].loop;
				endcase
			end
		end

		if (psel && penable && pwrite && hit) begin
			// Reserved bits are masked so they always read back as zero
			case (hitKind)
				2'd0: s_next.ch[hitChan].cfg = pwdata[7:0] & RX_CFG2_MASK;
				2'd1: s_next.ch[hitChan].pat = pwdata[7:0] & PAT_CTRL_MASK;
				default: s_next.ch[hitChan].loop = pwdata[7:0] & LOOP_CTRL_MASK;
			endcase
		end

		for (int i = 0; i < NUM_CHAN; i++) begin
			c = s_reg.ch[i];
			patSel = c.pat[TX_PATTERN_SELECT_SEL_LSB +: 2];
			losNow = chanIn[i].losActive;
			s_next.ch[i].txSync = {c.txSync[0], chanIn[i].txClock};
			s_next.ch[i].txPrev = c.txSync[1];
			bitEn[i] = c.pat[PATTERN_CLOCK_SELECT_BIT] ? s_reg.mclkEn : (c.txSync[1] & ~c.txPrev);
			// E1 uses x^15+x^14+1, T1/J1 uses x^20+x^17+1
			prbsFb[i] = chanIn[i].e1Mode ? (c.lfsr[14] ^ c.lfsr[13]) : (c.lfsr[19] ^ c.lfsr[16]);

			case (patSel)
				TX_PATTERN_SELECT_NORMAL: patBit = c.pat[PATTERN_CLOCK_SELECT_BIT] ? 1'b0 : chanIn[i].txData;
				TX_PATTERN_SELECT_ONES: begin
					// With auto all-ones set, ones are forced only while the signal is lost; otherwise the traffic bit is sent
					if (c.pat[AUTO_ONES_BIT] && !losNow) begin
						patBit = chanIn[i].txData;
					end else begin
						patBit = 1'b1;
					end
				end
				TX_PATTERN_SELECT_PRBS: patBit = prbsFb[i] ^ c.pat[PRBS_INVERT_BIT];
				TX_PATTERN_SELECT_INBAND: patBit = INBAND_CODE[INBAND_LAST - c.codeIdx];
				default: patBit = 1'b0;
			endcase

			if (bitEn[i]) begin
				if (patSel == TX_PATTERN_SELECT_PRBS) begin
					s_next.ch[i].lfsr = {c.lfsr[18:0], prbsFb[i]};
				end
				if (patSel == TX_PATTERN_SELECT_INBAND) begin
					s_next.ch[i].codeIdx = (c.codeIdx == INBAND_LAST) ? 3'd0 : c.codeIdx + 3'd1;
				end else begin
					s_next.ch[i].codeIdx = 3'd0;
				end
				s_next.ch[i].txLine = patBit;
			end
			// Remote loopback retransmits every received mark and overrides the pattern
			if (c.loop[RLOOP_BIT]) begin
				s_next.ch[i].txLine = chanIn[i].rxDataPos | chanIn[i].rxDataNeg;
			end

			// Receive side: digital loopback first, then alarm insertion, else pass through
			if (c.loop[DLOOP_BIT]) begin
				s_next.ch[i].rxPos = c.txLine;
				s_next.ch[i].rxNeg = 1'b0;
				s_next.ch[i].rxClk = s_reg.mclkCnt < (MCLK_DIV >> 1);
			end else if (c.pat[ALARM_INS_BIT] && losNow) begin
				// Marks alternate polarity so the forced ones form legal bipolar code
				if (s_reg.mclkEn) begin
					s_next.ch[i].aisPhase = ~c.aisPhase;
				end
				s_next.ch[i].rxPos = c.aisPhase;
				s_next.ch[i].rxNeg = ~c.aisPhase;
				s_next.ch[i].rxClk = s_reg.mclkCnt < (MCLK_DIV >> 1);
			end else begin
				s_next.ch[i].rxPos = chanIn[i].rxDataPos;
				s_next.ch[i].rxNeg = chanIn[i].rxDataNeg;
				s_next.ch[i].rxClk = chanIn[i].rxClock;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			for (int i = 0; i < NUM_CHAN; i++) begin
				s_reg.ch[i].cfg <= RX_CFG2_RESET;
				s_reg.ch[i].pat <= PAT_CTRL_RESET;
				s_reg.ch[i].loop <= LOOP_CTRL_RESET;
				s_reg.ch[i].lfsr <= LFSR_SEED;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			chanOut[i].slicerThreshold = s_reg.ch[i].cfg[SLICER_LSB +: 2];
			chanOut[i].eqObserveWindow = s_reg.ch[i].cfg[EQ_WIN_LSB +: 2];
			chanOut[i].monitorGain = s_reg.ch[i].cfg[MON_GAIN_LSB +: 2];
			chanOut[i].losAlarmCriterion = s_reg.ch[i].pat[LOS_CRIT_BIT];
			chanOut[i].autoRemoteLoopEn = s_reg.ch[i].loop[AUTO_RLOOP_BIT];
			chanOut[i].remoteLoopEn = s_reg.ch[i].loop[RLOOP_BIT];
			chanOut[i].analogLoopEn = s_reg.ch[i].loop[ALOOP_BIT];
			chanOut[i].digitalLoopEn = s_reg.ch[i].loop[DLOOP_BIT];
			chanOut[i].txLineData = s_reg.ch[i].txLine;
			chanOut[i].rxDataPos = s_reg.ch[i].rxPos;
			chanOut[i].rxDataNeg = s_reg.ch[i].rxNeg;
			chanOut[i].rxClock = s_reg.ch[i].rxClk;
		end
	end

	// Checks on channel one, plus the channel two readback and remote loop checks
	logic        wrAcc;
	logic        rdSetup;
	chan_state_t c0;
	logic [1:0]  pat0;
	assign wrAcc = psel & penable & pwrite;
	assign rdSetup = psel & ~penable & ~pwrite;
	assign c0 = s_reg.ch[0];
	assign pat0 = c0.pat[TX_PATTERN_SELECT_SEL_LSB +: 2];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_SLICER_WRITE: assert property (wrAcc && regIdx == CH1_RX_CFG2_IDX |=>
		chanOut[0].slicerThreshold == $past(pwdata[5:4])) else $error("slicer threshold not written");
	AST_WINDOW_GAIN_WRITE: assert property (wrAcc && regIdx == CH1_RX_CFG2_IDX |=>
		chanOut[0].eqObserveWindow == $past(pwdata[3:2]) && chanOut[0].monitorGain == $past(pwdata[1:0]))
		else $error("window or gain not written");
	AST_ZEROS_ON_MCLK: assert property (bitEn[0] && pat0 == TX_PATTERN_SELECT_NORMAL && c0.pat[PATTERN_CLOCK_SELECT_BIT]
		&& !c0.loop[RLOOP_BIT] |=> !chanOut[0].txLineData) else $error("all zeros not sent");
	AST_PRBS_E1: assert property (bitEn[0] && pat0 == TX_PATTERN_SELECT_PRBS && chanIn[0].e1Mode |=>
		c0.lfsr[0] == $past(c0.lfsr[14] ^ c0.lfsr[13])) else $error("E1 sequence wrong");
	AST_INBAND_LAST: assert property (bitEn[0] && pat0 == TX_PATTERN_SELECT_INBAND && c0.codeIdx == INBAND_LAST
		&& !c0.loop[RLOOP_BIT] |=> chanOut[0].txLineData && c0.codeIdx == 3'd0) else $error("inband code wrong");
	AST_HOLD_NO_EDGE: assert property (!bitEn[0] && !c0.loop[RLOOP_BIT] |=>
		$stable(chanOut[0].txLineData)) else $error("line changed without pattern clock");
	AST_PRBS_INVERT: assert property (bitEn[0] && pat0 == TX_PATTERN_SELECT_PRBS && c0.pat[PRBS_INVERT_BIT]
		&& !c0.loop[RLOOP_BIT] |=> chanOut[0].txLineData == !$past(prbsFb[0])) else $error("inversion missing");
	AST_CRITERION_WRITE: assert property (wrAcc && regIdx == CH1_PAT_CTRL_IDX |=>
		chanOut[0].losAlarmCriterion == $past(pwdata[2])) else $error("criterion not written");
	AST_ALARM_INSERT: assert property (c0.pat[ALARM_INS_BIT] && chanIn[0].losActive && !c0.loop[DLOOP_BIT]
		|=> chanOut[0].rxDataPos != chanOut[0].rxDataNeg) else $error("alarm not inserted");
	AST_NO_ALARM: assert property (!c0.pat[ALARM_INS_BIT] && !c0.loop[DLOOP_BIT] |=>
		chanOut[0].rxDataPos == $past(chanIn[0].rxDataPos)) else $error("receive data altered");
	AST_AUTO_ONES: assert property (bitEn[0] && pat0 == TX_PATTERN_SELECT_ONES && c0.pat[AUTO_ONES_BIT]
		&& !c0.loop[RLOOP_BIT] |=> chanOut[0].txLineData == $past(chanIn[0].losActive | chanIn[0].txData))
		else $error("auto all ones wrong");
	AST_LOOP_WRITE: assert property (wrAcc && regIdx == CH1_LOOP_CTRL_IDX |=>
		chanOut[0].autoRemoteLoopEn == $past(pwdata[3]) && chanOut[0].analogLoopEn == $past(pwdata[1]))
		else $error("loopback bits not written");
	AST_REMOTE_LOOP: assert property (c0.loop[RLOOP_BIT] |=>
		chanOut[0].txLineData == $past(chanIn[0].rxDataPos | chanIn[0].rxDataNeg)) else $error("remote loop wrong");
	AST_DIGITAL_LOOP: assert property (c0.loop[DLOOP_BIT] |=>
		chanOut[0].rxDataPos == $past(c0.txLine) && !chanOut[0].rxDataNeg) else $error("digital loop wrong");
	AST_READBACK: assert property (rdSetup && hit ##1 psel && penable |->
		prdata[31:8] == 24'h00_0000) else $error("upper read data not zero");
	AST_RESERVED_ZERO: assert property (rdSetup && regIdx == CH2_RX_CFG2_IDX |=>
		prdata[7:6] == 2'b00 && prdata[5:0] == $past(s_reg.ch[1].cfg[5:0])) else $error("reserved bits read");
	AST_RX_CLOCK_PASS: assert property (!c0.pat[ALARM_INS_BIT] && !c0.loop[DLOOP_BIT] |=>
		chanOut[0].rxClock == $past(chanIn[0].rxClock)) else $error("receive clock altered");
	AST_CH2_REMOTE_LOOP: assert property (s_reg.ch[1].loop[RLOOP_BIT] |=>
		chanOut[1].txLineData == $past(chanIn[1].rxDataPos | chanIn[1].rxDataNeg))
		else $error("channel two remote loop wrong");

	COV_PRBS_T1: cover property (bitEn[0] && pat0 == TX_PATTERN_SELECT_PRBS && !chanIn[0].e1Mode);
	COV_AIS: cover property (c0.pat[ALARM_INS_BIT] && chanIn[0].losActive ##1 chanOut[0].rxDataNeg);
	COV_UNMAPPED: cover property (pslverr);
	COV_REMOTE: cover property (c0.loop[RLOOP_BIT] ##1 chanOut[0].txLineData);
endmodule

/* line_diag_control_regs_test.sv */
// Self-checking bench for the line diagnostics control registers
`timescale 1ns/1ps
module line_diag_control_regs_test;
	import line_diag_pkg::*;
	logic            clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic            txRun = 1'b1, e1 = 1'b1, err, pready, pslverr;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0000_0000, prdata, rd;
	logic [1:0]      txBit = 2'h0, rxPos = 2'h0, los = 2'h0;
	logic [63:0]     bits;
	logic [5:0]      off;
	int              n_errors = 0, cmp_count = 0, ones;
	chan_in_t  [1:0] chanIn;
	chan_out_t [1:0] chanOut;
	logic [5:0]      idxs [3] = '{CH1_RX_CFG2_IDX, CH1_PAT_CTRL_IDX, CH1_LOOP_CTRL_IDX};
	logic [7:0]      rstv [3] = '{8'h18, 8'h00, 8'h00};
	logic [7:0]      mskv [3] = '{8'h3F, 8'h7F, 8'h0F};
	// Pattern byte, traffic bit, loss of signal, expected line bit
	logic [10:0]     tbl [7] = '{{8'h30, 3'h1}, {8'h10, 3'h4}, {8'h00, 3'h5}, {8'h20, 3'h1},
		{8'h21, 3'h0}, {8'h21, 3'h3}, {8'h01, 3'h2}};

	line_diag_control_regs u_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chanIn(chanIn), .chanOut(chanOut));
	line_diag_line_model u_line (.clk(clk), .rst_n(rst_n), .txRun(txRun), .txBit(txBit), .rxPos(rxPos),
		.los(los), .e1(e1), .chanIn(chanIn));

	always #12.5 clk = ~clk;

	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic [5:0] idx, input logic wr, input logic [7:0] wd);
		int n;
		@(posedge clk);
		paddr <= {idx, 2'h0};
		pwrite <= wr;
		pwdata <= {24'h00_0000, wd};
		psel <= 1'b1;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			print_verdict();
		end
	endtask

	task automatic rdc(input string s, input logic [5:0] idx, input logic [7:0] e);
		apb(idx, 1'b0, 8'h00);
		check(s, rd, {24'h00_0000, e});
	endtask

	// One sample per master clock bit; the lead-in skips bits sent under the old pattern
	task automatic grab(input int n);
		repeat (40) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (20) @(negedge clk);
			bits[i] = chanOut[0].txLineData;
		end
	endtask

	task automatic watch();
		ones = 0;
		repeat (60) @(negedge clk) ones += chanOut[0].rxDataPos;
	endtask

	task automatic prbs(input logic inv, input int len, input int tap);
		logic ok1 = 1'b1;
		logic ok2 = 1'b1;
		apb(CH1_PAT_CTRL_IDX, 1'b1, {4'h5, inv, 3'h0});
		grab(64);
		for (int n = len; n < 64; n++) begin
			ok1 &= bits[n] == (bits[n-tap] ^ bits[n-len] ^ inv);
			ok2 &= bits[n] == (bits[n-len+tap] ^ bits[n-len] ^ inv);
		end
		check("prbs", (ok1 | ok2) && bits != '0 && bits != '1, 1);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		check("rxcfg fields", {chanOut[0].slicerThreshold, chanOut[0].eqObserveWindow, chanOut[0].monitorGain}, 6'h18);
		for (int c = 0; c < 2; c++) begin
			off = c ? 6'h20 : 6'h00;
			for (int r = 0; r < 3; r++) begin
				rdc("reset", idxs[r] + off, rstv[r]);
				apb(idxs[r] + off, 1'b1, 8'hFF);
				rdc("reserved", idxs[r] + off, mskv[r]);
			end
		end
		for (int r = 0; r < 3; r++) begin
			apb(idxs[r], 1'b1, 8'h00);
			rdc("other chan", idxs[r] + 6'h20, mskv[r]);
			apb(idxs[r] + 6'h20, 1'b1, 8'h00);
		end
		rdc("unmapped", 6'h00, 8'h00);
		check("slverr", err, 1);
		for (int v = 0; v < 4; v++) begin
			apb(CH2_RX_CFG2_IDX, 1'b1, {2'h0, v[1:0], v[1:0], v[1:0]});
			// Fields show the new value only after the access edge has settled
			@(negedge clk);
			check("codes", {chanOut[1].slicerThreshold, chanOut[1].eqObserveWindow, chanOut[1].monitorGain}, {3{v[1:0]}});
			apb(CH1_LOOP_CTRL_IDX, 1'b1, 8'h01 << v);
			@(negedge clk);
			check("loops", {chanOut[0].autoRemoteLoopEn, chanOut[0].remoteLoopEn, chanOut[0].analogLoopEn,
				chanOut[0].digitalLoopEn}, 4'h1 << v);
		end
		apb(CH1_LOOP_CTRL_IDX, 1'b1, 8'h00);
		apb(CH1_PAT_CTRL_IDX, 1'b1, 8'h04);
		@(negedge clk);
		check("criterion", chanOut[0].losAlarmCriterion, 1);
		for (int i = 0; i < 7; i++) begin
			apb(CH1_PAT_CTRL_IDX, 1'b1, tbl[i][10:3]);
			txBit[0] <= tbl[i][2];
			los[0] <= tbl[i][1];
			repeat (60) @(negedge clk);
			check("tx pattern", chanOut[0].txLineData, tbl[i][0]);
			@(posedge clk);
		end
		txRun <= 1'b0;
		// Let a clock edge already in the synchroniser land before the traffic bit changes
		repeat (4) @(posedge clk);
		txBit[0] <= 1'b1;
		repeat (60) @(negedge clk);
		check("stalled clock", chanOut[0].txLineData, 0);
		@(posedge clk);
		txRun <= 1'b1;
		repeat (60) @(negedge clk);
		check("tx clock", chanOut[0].txLineData, 1);
		prbs(1'b0, 15, 1);
		@(posedge clk);
		e1 <= 1'b0;
		prbs(1'b1, 20, 3);
		apb(CH1_PAT_CTRL_IDX, 1'b1, 8'h70);
		grab(10);
		check("inband", bits[9:5] == bits[4:0] && $countones(bits[4:0]) == 1, 1);
		apb(CH1_PAT_CTRL_IDX, 1'b1, 8'h30);
		apb(CH1_LOOP_CTRL_IDX, 1'b1, 8'h04);
		for (int v = 0; v < 2; v++) begin
			rxPos[0] <= v[0];
			repeat (5) @(negedge clk);
			check("remote loop", chanOut[0].txLineData, v);
			@(posedge clk);
		end
		apb(CH1_LOOP_CTRL_IDX, 1'b1, 8'h01);
		apb(CH1_PAT_CTRL_IDX, 1'b1, 8'h32);
		los[0] <= 1'b1;
		watch();
		check("digital loop", ones, 60);
		apb(CH1_LOOP_CTRL_IDX, 1'b1, 8'h00);
		watch();
		check("alarm insert", ones > 0 && ones < 60, 1);
		apb(CH1_PAT_CTRL_IDX, 1'b1, 8'h30);
		rxPos[0] <= 1'b0;
		@(posedge clk);
		watch();
		check("no alarm", ones, 0);
		check("no alarm neg", chanOut[0].rxDataNeg, 0);
		print_verdict();
	end
endmodule

/* line_diag_line_model.sv */
// Line side model: transmit clock and traffic, receive rails and loss of signal per channel
`timescale 1ns/1ps
module line_diag_line_model (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   txRun,
	input  wire logic [1:0]             txBit,
	input  wire logic [1:0]             rxPos,
	input  wire logic [1:0]             los,
	input  wire logic                   e1,
	output line_diag_pkg::chan_in_t [1:0] chanIn
);
	import line_diag_pkg::*;
	logic [2:0] div;

	// Transmit clock stops while idle, so a stalled line gives no bit enables while the transmit clock is the pattern clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 3'h0;
		end else if (txRun) begin
			div <= div + 3'h1;
		end
	end

	always_comb begin
		for (int c = 0; c < NUM_CHAN; c++) begin
			chanIn[c].txClock   = div[2];
			chanIn[c].txData    = txBit[c];
			chanIn[c].rxDataPos = rxPos[c];
			chanIn[c].rxDataNeg = 1'b0;
			chanIn[c].rxClock   = div[1];
			chanIn[c].losActive = los[c];
			chanIn[c].e1Mode    = e1;
		end
	end
endmodule

/* line_diag_pkg.sv */
// Constants, field layout and carrier types of the line diagnostics control registers
package line_diag_pkg;
	localparam int NUM_CHAN = 2;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] CH1_RX_CFG2_IDX = 6'h0B;
	localparam logic [5:0] CH1_PAT_CTRL_IDX = 6'h0C;
	localparam logic [5:0] CH1_LOOP_CTRL_IDX = 6'h0D;
	localparam logic [5:0] CH2_RX_CFG2_IDX = 6'h2B;
	localparam logic [5:0] CH2_PAT_CTRL_IDX = 6'h2C;
	localparam logic [5:0] CH2_LOOP_CTRL_IDX = 6'h2D;
	// Field positions
	localparam int SLICER_LSB = 4;
	localparam int EQ_WIN_LSB = 2;
	localparam int MON_GAIN_LSB = 0;
	localparam int TX_PATTERN_SELECT_SEL_LSB = 5;
	localparam int PATTERN_CLOCK_SELECT_BIT = 4;
	localparam int PRBS_INVERT_BIT = 3;
	localparam int LOS_CRIT_BIT = 2;
	localparam int ALARM_INS_BIT = 1;
	localparam int AUTO_ONES_BIT = 0;
	localparam int AUTO_RLOOP_BIT = 3;
	localparam int RLOOP_BIT = 2;
	localparam int ALOOP_BIT = 1;
	localparam int DLOOP_BIT = 0;
	// Writable bits and reset values
	localparam logic [7:0] RX_CFG2_MASK = 8'h3F;
	localparam logic [7:0] PAT_CTRL_MASK = 8'h7F;
	localparam logic [7:0] LOOP_CTRL_MASK = 8'h0F;
	localparam logic [7:0] RX_CFG2_RESET = 8'h18;
	localparam logic [7:0] PAT_CTRL_RESET = 8'h00;
	localparam logic [7:0] LOOP_CTRL_RESET = 8'h00;
	// Pattern generator
	localparam logic [1:0] TX_PATTERN_SELECT_NORMAL = 2'b00;
	localparam logic [1:0] TX_PATTERN_SELECT_ONES = 2'b01;
	localparam logic [1:0] TX_PATTERN_SELECT_PRBS = 2'b10;
	localparam logic [1:0] TX_PATTERN_SELECT_INBAND = 2'b11;
	localparam logic [19:0] LFSR_SEED = 20'hF_FFFF;
	localparam logic [4:0] INBAND_CODE = 5'h01;
	localparam logic [2:0] INBAND_LAST = 3'h4;
	// Master clock bit rate as a divider of the system clock
	localparam logic [4:0] MCLK_DIV = 5'h14;

	typedef struct packed {
		logic txClock;
		logic txData;
		logic rxDataPos;
		logic rxDataNeg;
		logic rxClock;
		logic losActive;
		logic e1Mode;
	} chan_in_t;

	typedef struct packed {
		logic [1:0] slicerThreshold;
		logic [1:0] eqObserveWindow;
		logic [1:0] monitorGain;
		logic       losAlarmCriterion;
		logic       autoRemoteLoopEn;
		logic       remoteLoopEn;
		logic       analogLoopEn;
		logic       digitalLoopEn;
		logic       txLineData;
		logic       rxDataPos;
		logic       rxDataNeg;
		logic       rxClock;
	} chan_out_t;

	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  pat;
		logic [7:0]  loop;
		logic [19:0] lfsr;
		logic [2:0]  codeIdx;
		logic [1:0]  txSync;
		logic        txPrev;
		logic        txLine;
		logic        rxPos;
		logic        rxNeg;
		logic        rxClk;
		logic        aisPhase;
	} chan_state_t;

	typedef struct packed {
		chan_state_t [NUM_CHAN-1:0] ch;
		logic [31:0]                prdata;
		logic [4:0]                 mclkCnt;
		logic                       mclkEn;
	} diag_state_t;
endpackage
